// ==== rtl/system_clock_prescaler.sv ====
// system clock prescaler with timer oscillator pin sharing
//
// Summary of operation
// RL1 - timer oscillator gets the shared pins only while the RC oscillator clocks the chip
// RL2 - external clock select lets the timer input accept a driven clock
// RL3 - one divide factor feeds io, converter, cpu and flash clocks alike
// RL4 - divide control at index 0x61: unlock bit 7, zeros 6..4, select 3..0
// RL5 - unlock bit sets only when the same write clears all other bits
// RL6 - unlock bit clears four cycles after setting, or on a select write
// RL7 - rewriting the unlock bit while open neither restarts nor clears it
// RL8 - software unlocks, then writes the new select within four cycles
// RL9 - software keeps interrupts off across the two writes
// RL10 - reset loads select 0000, or 0011 when the divide-by-eight fuse is programmed
// RL11 - any select value may be written through the unlock sequence
// RL12 - codes 0 to 8 divide by 1 to 256, higher codes are reserved
// RL13 - switching never glitches nor runs faster than old or new setting
// RL14 - new factor active within one old plus two new periods
// RL15 - division done by a master-rate counter that software cannot read
// RL16 - programmed clock output fuse puts the divided clock on the pin
// RL17 - reserved bits 6..4 ignore writes and read as zero
// RL18 - a select write without the unlock bit open changes nothing
`timescale 1ns/1ns
`default_nettype none
module system_clock_prescaler (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // avalon-mm slave, byte addressed
  input  wire logic [8:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // fuses, high when programmed
  input  wire logic        divide_by_eight_fuse,
  input  wire logic        clock_output_fuse,
  // clock source status
  input  wire logic        rc_osc_selected,
  // timer oscillator pins
  input  wire logic        timer_osc_in,
  output logic             main_crystal_to_timer,
  output logic             timer_osc_amp_en,
  output logic             timer_osc_ext_en,
  output logic             timer_ext_clock,
  // divided clock enables
  output logic             io_clock_en,
  output logic             converter_clock_en,
  output logic             cpu_clock_en,
  output logic             flash_clock_en,
  // clock output pin
  output logic             clock_output_pin,
  output logic             clock_output_oe_n
);

  prescaler_pkg::bus_state_e bus_q;
  logic [31:0] readdata_q;
  logic [3:0]  select_q;
  logic        open_q;
  logic        tosc_req_q;
  logic        tosc_ext_q;
  logic        grant_q;
  logic        amp_en_q;
  logic        ext_en_q;
  logic        ext_clk_q;
  logic        wr_fire;
  logic        ctrl_wr;
  logic        tosc_wr;
  logic [7:0]  wd;
  logic        arm;
  logic        cancel;
  logic [7:0]  ctrl_read;
  logic [7:0]  tosc_read;

  div_ctrl_if link ();

  // bus handshake: one wait cycle, then the access completes
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      bus_q <= prescaler_pkg::BUS_IDLE;
    end
    else
    begin
      unique case (bus_q)
        prescaler_pkg::BUS_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            bus_q <= prescaler_pkg::BUS_ACK;
          end
        end
        prescaler_pkg::BUS_ACK:
        begin
          bus_q <= prescaler_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && (bus_q != prescaler_pkg::BUS_ACK);
  assign wr_fire         = avs_write && (bus_q == prescaler_pkg::BUS_ACK);
  assign wd              = avs_writedata[7:0];
  assign ctrl_wr = wr_fire && avs_byteenable[0] && (avs_address == prescaler_pkg::CTRL_ADDR);
  assign tosc_wr = wr_fire && avs_byteenable[0] && (avs_address == prescaler_pkg::TOSC_ADDR);

  // unlock only from a clean write; select write needs an open window
  assign arm    = ctrl_wr && wd[prescaler_pkg::UNLOCK_BIT]
                  && ((wd & prescaler_pkg::OTHER_MASK) == 8'h00); // RL5
  assign cancel = ctrl_wr && !wd[prescaler_pkg::UNLOCK_BIT] && open_q; // RL6

  unlock_window u_unlock (
    .core_clk (core_clk),
    .nrst     (nrst),
    .arm      (arm),
    .cancel   (cancel),
    .open_q   (open_q)
  );

  // divide select; fuse level is caught under the synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      select_q <= divide_by_eight_fuse ? prescaler_pkg::SEL_RESET_DIV8
                                       : prescaler_pkg::SEL_RESET_PLAIN; // RL10
    end
    else if (cancel)
    begin
      select_q <= wd[prescaler_pkg::SEL_MSB:0]; // RL11 RL18
    end
  end

  // timer oscillator control bits
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      tosc_req_q <= 1'b0;
      tosc_ext_q <= 1'b0;
    end
    else if (tosc_wr)
    begin
      tosc_req_q <= wd[prescaler_pkg::TOSC_REQ_BIT];
      tosc_ext_q <= wd[prescaler_pkg::TOSC_EXT_BIT];
    end
  end

  // pins are shared with the main crystal, so only an RC-clocked chip may lend them
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      grant_q   <= 1'b0;
      amp_en_q  <= 1'b0;
      ext_en_q  <= 1'b0;
      ext_clk_q <= 1'b0;
    end
    else
    begin
      grant_q   <= tosc_req_q && rc_osc_selected; // RL1
      amp_en_q  <= grant_q && !tosc_ext_q;
      ext_en_q  <= grant_q && tosc_ext_q; // RL2
      ext_clk_q <= ext_en_q && timer_osc_in; // RL2
    end
  end

  assign main_crystal_to_timer = grant_q;
  assign timer_osc_amp_en      = amp_en_q;
  assign timer_osc_ext_en      = ext_en_q;
  assign timer_ext_clock       = ext_clk_q;

  // read views; reserved bits are hard zero
  assign ctrl_read = {open_q, prescaler_pkg::RSVD_READ, select_q}; // RL4 RL17
  assign tosc_read = {5'h00, grant_q, tosc_ext_q, tosc_req_q};

  // read data captured in the wait cycle, unmapped reads give zero
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      readdata_q <= 32'h0000_0000;
    end
    else if (avs_read && (bus_q == prescaler_pkg::BUS_IDLE))
    begin
      if (avs_address == prescaler_pkg::CTRL_ADDR)
      begin
        readdata_q <= {24'h00_0000, ctrl_read};
      end
      else if (avs_address == prescaler_pkg::TOSC_ADDR)
      begin
        readdata_q <= {24'h00_0000, tosc_read};
      end
      else
      begin
        readdata_q <= 32'h0000_0000;
      end
    end
  end

  assign avs_readdata = readdata_q;

  // divider core
  assign link.select = select_q;

  clk_div_core u_div (
    .core_clk (core_clk),
    .nrst     (nrst),
    .link     (link)
  );

  // every synchronous domain shares the same enable
  assign io_clock_en        = link.tick; // RL3
  assign converter_clock_en = link.tick; // RL3
  assign cpu_clock_en       = link.tick; // RL3
  assign flash_clock_en     = link.tick; // RL3

  // divide by one cannot be rebuilt from flops, so the master clock passes through
  assign clock_output_pin  = clock_output_fuse
                             && ((link.active == prescaler_pkg::SEL_RESET_PLAIN)
                                 ? core_clk : link.phase); // RL16
  assign clock_output_oe_n = !clock_output_fuse;

  a_unlock_clean: assert property (@(posedge core_clk) disable iff (!nrst) // RL5
    (ctrl_wr && !open_q && ((wd & prescaler_pkg::OTHER_MASK) != 8'h00)) |=> !open_q)
    else $error("unlock set by a write with other bits set");

  a_select_locked: assert property (@(posedge core_clk) disable iff (!nrst) // RL18
    (ctrl_wr && !open_q && !wd[prescaler_pkg::UNLOCK_BIT]) |=> $stable(select_q))
    else $error("select changed without unlock");

  a_select_loads: assert property (@(posedge core_clk) disable iff (!nrst) // RL11
    (ctrl_wr && open_q && !wd[prescaler_pkg::UNLOCK_BIT])
    |=> (select_q == $past(wd[prescaler_pkg::SEL_MSB:0])) && !open_q)
    else $error("unlocked select write not taken");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst) // RL17
    (avs_read && !avs_waitrequest && (avs_address == prescaler_pkg::CTRL_ADDR))
    |-> (avs_readdata[6:4] == prescaler_pkg::RSVD_READ) && (avs_readdata[31:8] == 24'h00_0000))
    else $error("reserved control bits read nonzero");

  a_fuse_reset: assert property (@(posedge core_clk) // RL10
    !nrst |=> (select_q == ($past(divide_by_eight_fuse) ? prescaler_pkg::SEL_RESET_DIV8
                                                        : prescaler_pkg::SEL_RESET_PLAIN)))
    else $error("select reset value ignores fuse");

  a_timer_grant: assert property (@(posedge core_clk) disable iff (!nrst) // RL1
    (timer_osc_amp_en || timer_osc_ext_en) |-> $past(rc_osc_selected, 2))
    else $error("timer oscillator enabled off the rc clock");

  c_change_seq: cover property (@(posedge core_clk) disable iff (!nrst)
    arm ##[2:4] cancel);

  c_reserved_code: cover property (@(posedge core_clk) disable iff (!nrst)
    cancel && (wd[prescaler_pkg::SEL_MSB:0] > prescaler_pkg::SEL_MAX));

endmodule // system_clock_prescaler
`default_nettype wire

// ==== rtl/prescaler_pkg.sv ====
// constants, register map and types for the system clock prescaler
package prescaler_pkg;

  // master clock rate
  localparam int unsigned CLK_HZ = 10_000_000;

  // register indices; the byte address is four times the index
  localparam logic [6:0] CTRL_INDEX = 7'h61;
  localparam logic [6:0] TOSC_INDEX = 7'h62;
  localparam logic [8:0] CTRL_ADDR  = {CTRL_INDEX, 2'h0};
  localparam logic [8:0] TOSC_ADDR  = {TOSC_INDEX, 2'h0};

  // divide control field layout
  localparam int unsigned UNLOCK_BIT = 7;
  localparam int unsigned SEL_MSB    = 3;
  localparam logic [7:0]  OTHER_MASK = 8'h7f;
  localparam logic [2:0]  RSVD_READ  = 3'h0;

  // divide select reset values and largest legal code
  localparam logic [3:0] SEL_RESET_PLAIN = 4'h0;
  localparam logic [3:0] SEL_RESET_DIV8  = 4'h3;
  localparam logic [3:0] SEL_MAX         = 4'h8;

  // unlock window length in master clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // timer oscillator control field layout
  localparam int unsigned TOSC_REQ_BIT   = 0;
  localparam int unsigned TOSC_EXT_BIT   = 1;
  localparam int unsigned TOSC_GRANT_BIT = 2;

  // bus slave states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_e;

endpackage

// ==== rtl/div_ctrl_if.sv ====
// link between the register logic and the divider core
`timescale 1ns/1ns
`default_nettype none
interface div_ctrl_if;
  logic [3:0] select;   // requested divide select code
  logic [3:0] active;   // code of the period now running
  logic       tick;     // one cycle per divided period
  logic       phase;    // high in the first half of a period

  modport ctrl (output select, input active, input tick, input phase);
  modport core (input select, output active, output tick, output phase);
endinterface
`default_nettype wire

// ==== rtl/clk_div_core.sv ====
// power-of-two divider with period-boundary switching
`timescale 1ns/1ns
`default_nettype none
module clk_div_core (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   nrst,
  // control link
  div_ctrl_if.core    link
);

  logic [7:0] cnt_q;
  logic [3:0] act_q;
  logic       phase_q;
  logic [3:0] lim_sel;
  logic [7:0] cnt_d;

  // reserved codes clamp to the slowest legal factor
  function automatic logic [3:0] limit(input logic [3:0] s);
    limit = (s > prescaler_pkg::SEL_MAX) ? prescaler_pkg::SEL_MAX : s;
  endfunction

  function automatic logic [8:0] period(input logic [3:0] s);
    period = 9'h001 << s;
  endfunction

  assign lim_sel = limit(link.select);

  // new factor only taken at a period end, so no short pulse appears
  always_comb
  begin
    if (cnt_q == 8'h00)
    begin
      cnt_d = 8'(period(lim_sel) - 9'h001); // RL13 RL14
    end
    else
    begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  // master-rate down counter, invisible to software
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cnt_q <= 8'h00;
    end
    else
    begin
      cnt_q <= cnt_d; // RL15
    end
  end

  // active code follows the request at a period end
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      act_q <= prescaler_pkg::SEL_RESET_PLAIN;
    end
    else if (cnt_q == 8'h00)
    begin
      act_q <= lim_sel; // RL12
    end
  end

  // half-period phase for the clock output pin
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      phase_q <= 1'b0;
    end
    else if (cnt_q == 8'h00)
    begin
      phase_q <= 1'b1;
    end
    else
    begin
      phase_q <= ({1'b0, cnt_d} >= (period(act_q) >> 1));
    end
  end

  assign link.tick   = (cnt_q == 8'h00);
  assign link.active = act_q;
  assign link.phase  = phase_q;

  // helper: cycles since the previous tick and the code it started
  logic [8:0] gap_q;
  logic [3:0] last_q;
  logic       seen_q;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      gap_q  <= 9'h000;
      last_q <= 4'h0;
      seen_q <= 1'b0;
    end
    else if (link.tick)
    begin
      gap_q  <= 9'h000;
      last_q <= lim_sel;
      seen_q <= 1'b1;
    end
    else
    begin
      gap_q <= gap_q + 9'h001;
    end
  end

  a_period_exact: assert property (@(posedge core_clk) disable iff (!nrst) // RL13
    (link.tick && seen_q) |-> (gap_q == 9'(period(last_q) - 9'h001)))
    else $error("divided period differs from its factor");

  a_switch_bound: assert property (@(posedge core_clk) disable iff (!nrst) // RL14
    (lim_sel != act_q) && $stable(lim_sel) |-> ##[0:256] (act_q == lim_sel))
    else $error("new divide factor not active in time");

  c_slowest: cover property (@(posedge core_clk) disable iff (!nrst)
    link.tick && (act_q == prescaler_pkg::SEL_MAX));

endmodule // clk_div_core
`default_nettype wire

// ==== rtl/unlock_window.sv ====
// timed change-unlock bit
`timescale 1ns/1ns
`default_nettype none
module unlock_window (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   nrst,
  // requests
  input  wire logic   arm,
  input  wire logic   cancel,
  // state
  output logic        open_q
);

  logic [2:0] cnt_q;

  // rearming an open window is ignored, so it never stretches
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      open_q <= 1'b0;
      cnt_q  <= 3'h0;
    end
    else if (open_q)
    begin
      if (cancel || (cnt_q == 3'h0))
      begin
        open_q <= 1'b0; // RL6 RL7
      end
      else
      begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
    else if (arm)
    begin
      open_q <= 1'b1;
      cnt_q  <= prescaler_pkg::UNLOCK_CYCLES - 3'h1; // RL8
    end
  end

  a_window_closes: assert property (@(posedge core_clk) disable iff (!nrst) // RL6
    $rose(open_q) ##0 (!cancel) [*4] |=> !open_q)
    else $error("unlock window outlived four cycles");

  a_window_holds: assert property (@(posedge core_clk) disable iff (!nrst) // RL7
    $rose(open_q) ##0 (!cancel) [*3] |=> open_q)
    else $error("unlock window closed early");

  c_timeout: cover property (@(posedge core_clk) disable iff (!nrst)
    open_q && !cancel && (cnt_q == 3'h0));

endmodule // unlock_window
`default_nettype wire

// ==== bench/system_clock_prescaler_test.sv ====
// self-checking bench for the system clock prescaler
`timescale 1ns/1ns
`default_nettype none
module system_clock_prescaler_test;
  localparam logic [8:0] CA = prescaler_pkg::CTRL_ADDR;
  localparam logic [8:0] TA = prescaler_pkg::TOSC_ADDR;

  logic        core_clk;
  logic        nrst;
  logic [8:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        divide_by_eight_fuse;
  logic        clock_output_fuse;
  logic        rc_osc_selected;
  logic        timer_osc_in;
  logic        main_crystal_to_timer;
  logic        timer_osc_amp_en;
  logic        timer_osc_ext_en;
  logic        timer_ext_clock;
  logic        io_clock_en;
  logic        converter_clock_en;
  logic        cpu_clock_en;
  logic        flash_clock_en;
  logic        clock_output_pin;
  logic        clock_output_oe_n;
  logic [7:0]  rd;
  int          err_total;
  int          tests_run;
  int          per;

  system_clock_prescaler dut (
    .core_clk(core_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .divide_by_eight_fuse(divide_by_eight_fuse), .clock_output_fuse(clock_output_fuse),
    .rc_osc_selected(rc_osc_selected), .timer_osc_in(timer_osc_in),
    .main_crystal_to_timer(main_crystal_to_timer), .timer_osc_amp_en(timer_osc_amp_en),
    .timer_osc_ext_en(timer_osc_ext_en), .timer_ext_clock(timer_ext_clock),
    .io_clock_en(io_clock_en), .converter_clock_en(converter_clock_en),
    .cpu_clock_en(cpu_clock_en), .flash_clock_en(flash_clock_en),
    .clock_output_pin(clock_output_pin), .clock_output_oe_n(clock_output_oe_n)
  );

  // 10 mhz master clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low, left up after
  // waitrequest and read data are looked at mid-cycle, clear of the edge that moves them
  task automatic xfer(input logic w, input logic [8:0] a, input logic [7:0] d);
    int   n;
    logic done;
    n    = 0;
    done = 1'b0;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= w;
    avs_read      <= ~w;
    do
    begin
      @(negedge core_clk);
      n++;
      done = (avs_waitrequest === 1'b0);
      rd   = avs_readdata[7:0];
      @(posedge core_clk);
    end
    while (!done && n < 50);
    if (n >= 50)
    begin
      err_total++;
      $display("ERROR at %0t: bus hang got %h expected %h", $time, avs_waitrequest, 1'b0);
      complete_run();
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [8:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check({8'h00, rd}, {8'h00, exp});
  endtask

  // release the bus; window timing below counts these edges exactly
  task automatic idle(input int n);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic do_reset(input logic fuse);
    nrst                 <= 1'b0;
    divide_by_eight_fuse <= fuse;
    idle(20);
    nrst <= 1'b1;
    @(posedge core_clk);
  endtask

  task automatic setsel(input logic [3:0] c);
    wr(CA, 8'h80);
    wr(CA, {4'h0, c});
    idle(1);
  endtask

  // cycles up to the next enable pulse, all four enables compared meanwhile
  task automatic wait_en(output int n);
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
      check({13'h0, io_clock_en, converter_clock_en, flash_clock_en}, {13'h0, {3{cpu_clock_en}}});
    end
    while (cpu_clock_en !== 1'b1 && n < 600);
    if (n >= 600)
    begin
      err_total++;
      $display("ERROR at %0t: no enable got %h expected %h", $time, cpu_clock_en, 1'b1);
      complete_run();
    end
    @(posedge core_clk);
  endtask

  // main sequence
  initial
  begin
    err_total = 0;
    tests_run = 0;
    nrst = 1'b0;
    avs_address = 9'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    divide_by_eight_fuse = 1'b1;
    clock_output_fuse = 1'b1;
    rc_osc_selected = 1'b0;
    timer_osc_in = 1'b0;
    @(posedge core_clk);
    do_reset(1'b1);
    rdchk(CA, 8'h03);
    idle(1);
    do_reset(1'b0);
    rdchk(CA, 8'h00);
    rdchk(9'h000, 8'h00);
    wr(CA, 8'h81);
    wr(CA, 8'h05);
    rdchk(CA, 8'h00);
    wr(CA, 8'h80);
    rdchk(CA, 8'h80);
    idle(4);
    rdchk(CA, 8'h00);
    // late in the window, reserved bits dropped
    wr(CA, 8'h80);
    idle(1);
    wr(CA, 8'h75);
    rdchk(CA, 8'h05);
    // one edge past the window
    wr(CA, 8'h80);
    idle(3);
    wr(CA, 8'h02);
    rdchk(CA, 8'h05);
    // a second unlock must not extend the window
    wr(CA, 8'h80);
    wr(CA, 8'h80);
    idle(1);
    wr(CA, 8'h02);
    rdchk(CA, 8'h05);
    idle(1);
    setsel(4'h9);
    rdchk(CA, 8'h09);
    avs_byteenable <= 4'h0;
    wr(CA, 8'h80);
    wr(CA, 8'h01);
    avs_byteenable <= 4'hf;
    rdchk(CA, 8'h09);
    idle(1);
    // every legal factor, settled over two pulses before measuring
    for (int c = 0; c <= 8; c++)
    begin
      setsel(c[3:0]);
      wait_en(per);
      wait_en(per);
      wait_en(per);
      check(per[15:0], 16'h1 << c);
      check({15'h0, clock_output_oe_n}, 16'h0);
    end
    // timer oscillator refused while the rc oscillator is not the source
    wr(TA, 8'h01);
    idle(3);
    rdchk(TA, 8'h01);
    check({15'h0, timer_osc_amp_en}, 16'h0);
    rc_osc_selected <= 1'b1;
    idle(3);
    rdchk(TA, 8'h05);
    check({14'h0, timer_osc_amp_en, main_crystal_to_timer}, 16'h3);
    wr(TA, 8'h03);
    idle(3);
    check({15'h0, timer_osc_ext_en}, 16'h1);
    timer_osc_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({15'h0, timer_ext_clock}, 16'h1);
    timer_osc_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({15'h0, timer_ext_clock}, 16'h0);
    clock_output_fuse <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({14'h0, clock_output_pin, clock_output_oe_n}, 16'h1);
    complete_run();
  end
endmodule // system_clock_prescaler_test
`default_nettype wire
